// *** sim/svs_vt_model.sv ***
// Purpose: three-phase voltage transformer stand-in feeding phasor samples
// Assumes: bench sets positive and negative sequence amplitudes
// Notes:   phasors are inverted between samples so stale words never look valid
`timescale 1ns/100ps
`default_nettype none
module svs_vt_model (
  input  wire logic               clk,
  input  wire logic               arst_n,
  input  wire logic signed [15:0] pos_amp,
  input  wire logic signed [15:0] neg_amp,
  output logic                    meas_valid,
  output logic signed [15:0]      va_re,
  output logic signed [15:0]      va_im,
  output logic signed [15:0]      vb_re,
  output logic signed [15:0]      vb_im,
  output logic signed [15:0]      vc_re,
  output logic signed [15:0]      vc_im
);
  int   sum_v;
  int   dif_k;
  logic phase_r;

  // sqrt(3)/2 scaling of the sequence difference, integer only
  always_comb sum_v = int'(pos_amp) + int'(neg_amp);
  always_comb dif_k = ((int'(pos_amp) - int'(neg_amp)) * 28378) >>> 15;

  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      phase_r    <= 1'b0;
      meas_valid <= 1'b0;
    end
    else
    begin
      phase_r    <= ~phase_r;
      meas_valid <= phase_r;
    end
  end

  // every phase is built, so asymmetry is visible only across all three
  always_ff @(posedge clk)
  begin
    if (phase_r)
    begin
      va_re <= 16'(sum_v);
      va_im <= 16'h0000;
      vb_re <= 16'(-sum_v / 2);
      vb_im <= 16'(-dif_k);
      vc_re <= 16'(-sum_v / 2);
      vc_im <= 16'(dif_k);
    end
    else
    begin
      va_re <= ~va_re;
      va_im <= ~va_im;
      vb_re <= ~vb_re;
      vb_im <= ~vb_im;
      vc_re <= ~vc_re;
      vc_im <= ~vc_im;
    end
  end
endmodule
`default_nettype wire

// *** sim/tb_sequence_voltage_supervision.sv ***
// Purpose: self-checking bench for the sequence voltage supervision block
// Assumes: register reads answer one cycle after the strobe
// Notes:   amplitudes kept far from thresholds to absorb phasor rounding
`timescale 1ns/100ps
`default_nettype none
module tb_sequence_voltage_supervision;
  import svs_pkg::*;
  logic                     clock;
  logic                     arst_n;
  logic                     rd;
  logic                     wr;
  logic                     rd_q;
  logic [SVS_AW-1:0]        addr;
  logic [SVS_DW-1:0]        wdata;
  logic [SVS_DW-1:0]        rdata;
  logic signed [15:0]       pos;
  logic signed [15:0]       neg;
  logic                     mv;
  logic signed [15:0]       ph [6];
  logic                     alarm;
  logic                     trip;
  logic                     irq;
  logic [31:0]              exp_q [$];
  int                       miscompares;
  int                       checks;
  int                       cycles;
  int                       n;
  int                       amp;

  initial
  begin
    clock = 1'b0;
    forever #50 clock = ~clock;
  end

  svs_vt_model vt (.clk(clock), .arst_n(arst_n), .pos_amp(pos), .neg_amp(neg),
    .meas_valid(mv), .va_re(ph[0]), .va_im(ph[1]), .vb_re(ph[2]), .vb_im(ph[3]),
    .vc_re(ph[4]), .vc_im(ph[5]));

  svs_top uut (.CLOCK(clock), .ARST_N(arst_n), .MEAS_VALID(mv), .VA_RE(ph[0]),
    .VA_IM(ph[1]), .VB_RE(ph[2]), .VB_IM(ph[3]), .VC_RE(ph[4]), .VC_IM(ph[5]),
    .ADDR(addr), .WDATA(wdata), .WR(wr), .RD(rd), .RDATA(rdata), .ALARM(alarm),
    .TRIP(trip), .IRQ(irq));

  task chk(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp)
    begin
      miscompares++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task stop_test();
    $display("checks=%0d miscompares=%0d", checks, miscompares);
    if (miscompares == 0 && checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  task wr_reg(input logic [7:0] a, input logic [31:0] d);
    @(posedge clock);
    addr  <= a;
    wdata <= d;
    wr    <= 1'b1;
    @(posedge clock);
    wr    <= 1'b0;
  endtask

  task rd_reg(input logic [7:0] a, input logic [31:0] e);
    @(posedge clock);
    addr <= a;
    rd   <= 1'b1;
    exp_q.push_back(e);
    @(posedge clock);
    rd   <= 1'b0;
  endtask

  task set_ph(input int p, input int q);
    @(posedge clock);
    pos <= 16'(p);
    neg <= 16'(q);
  endtask

  // waits on alarm (sel 0) or trip (sel 1); cnt is negedges taken
  task wait_pin(input int sel, input logic v, input int lim, output int cnt);
    logic s;
    cnt = lim;
    for (int i = 0; i < lim; i++)
    begin
      @(negedge clock);
      s = sel ? trip : alarm;
      if (s === v)
      begin
        cnt = i + 1;
        break;
      end
    end
  endtask

  always @(posedge clock) rd_q <= rd;

  always @(negedge clock)
  begin
    if (rd_q === 1'b1)
    begin
      if (exp_q.size() == 0)
        chk(rdata, 32'hffffffff);
      else
        chk(rdata, exp_q.pop_front());
    end
  end

  always @(posedge clock)
  begin
    cycles++;
    if (cycles > 20000)
    begin
      miscompares++;
      stop_test();
    end
  end

  initial
  begin
    arst_n = 1'b0;
    rd     = 1'b0;
    wr     = 1'b0;
    addr   = '0;
    wdata  = '0;
    pos    = '0;
    neg    = '0;
    void'($urandom(32'he93fcd26));
    repeat (20) @(posedge clock);
    arst_n <= 1'b1;
    rd_reg(SVS_OFS_CTRL, 32'h0);
    rd_reg(SVS_OFS_THRESH, 32'hffff);
    rd_reg(SVS_OFS_RATIO, 32'h64);
    rd_reg(SVS_OFS_DELAY, 32'h0);
    rd_reg(SVS_OFS_IMASK, 32'h0);
    rd_reg(SVS_OFS_ISTAT, 32'h0);
    rd_reg(8'h1c, 32'h0);
    $display("test reset done");
    // positive overvoltage, delay 5 cycles
    wr_reg(SVS_OFS_THRESH, 32'd1000);
    wr_reg(SVS_OFS_DELAY, 32'd5);
    wr_reg(SVS_OFS_IMASK, 32'h3);
    wr_reg(SVS_OFS_CTRL, 32'h3);
    amp = 1500 + int'($urandom % 3000);
    set_ph(amp, 0);
    wait_pin(0, 1'b1, 20, n);
    chk(alarm, 1'b1);
    wait_pin(1, 1'b1, 20, n);
    chk(n, 6);
    chk(irq, 1'b1);
    rd_reg(SVS_OFS_ISTAT, 32'h3);
    repeat (2) @(negedge clock);
    chk(irq, 1'b0);
    $display("test overvoltage done");
    // short excursion must not trip; next crossing times from zero
    wr_reg(SVS_OFS_IMASK, 32'h0);
    wr_reg(SVS_OFS_DELAY, 32'd30);
    set_ph(500, 0);
    wait_pin(0, 1'b0, 20, n);
    chk(alarm, 1'b0);
    set_ph(amp, 0);
    wait_pin(0, 1'b1, 20, n);
    repeat (15) @(negedge clock);
    set_ph(500, 0);
    wait_pin(0, 1'b0, 20, n);
    chk(trip, 1'b0);
    chk(irq, 1'b0);
    set_ph(amp, 0);
    wait_pin(0, 1'b1, 20, n);
    wait_pin(1, 1'b1, 60, n);
    chk(n, 31);
    rd_reg(SVS_OFS_ISTAT, 32'h3);
    $display("test restart done");
    // positive undervoltage
    wr_reg(SVS_OFS_CTRL, 32'h5);
    wait_pin(0, 1'b0, 20, n);
    chk(alarm, 1'b0);
    set_ph(500, 0);
    wait_pin(0, 1'b1, 20, n);
    chk(alarm, 1'b1);
    $display("test undervoltage done");
    // negative sequence with ratio gate
    wr_reg(SVS_OFS_THRESH, 32'd500);
    wr_reg(SVS_OFS_RATIO, 32'd30);
    wr_reg(SVS_OFS_DELAY, 32'd5);
    wr_reg(SVS_OFS_CTRL, 32'h1);
    set_ph(4000, 1000);
    wait_pin(0, 1'b1, 20, n);
    chk(alarm, 1'b1);
    repeat (20) @(negedge clock);
    chk(trip, 1'b0);
    rd_reg(SVS_OFS_STATUS, 32'h1);
    wr_reg(SVS_OFS_RATIO, 32'd20);
    wait_pin(1, 1'b1, 10, n);
    chk(trip, 1'b1);
    rd_reg(SVS_OFS_STATUS, 32'h7);
    // zero percent: any negative sequence counts as unbalance
    wr_reg(SVS_OFS_RATIO, 32'd0);
    rd_reg(SVS_OFS_STATUS, 32'h7);
    // same phase A word, but balanced: no negative sequence
    set_ph(5000, 0);
    wait_pin(0, 1'b0, 20, n);
    chk(alarm, 1'b0);
    $display("test negative done");
    // off mode and disabled ignore samples
    for (int i = 0; i < 2; i++)
    begin
      wr_reg(SVS_OFS_CTRL, i ? 32'h0 : 32'h7);
      set_ph(0, 3000);
      repeat (20) @(negedge clock);
      chk(alarm, 1'b0);
      set_ph(5000, 0);
    end
    $display("test off done");
    repeat (3) @(posedge clock);
    stop_test();
  end
endmodule
`default_nettype wire

// *** verilog/svs_pkg.sv ***
// Purpose: shared constants and types for sequence voltage supervision
// Assumes: 32-bit register data, byte offsets on a plain register port
// Notes:   sequence magnitudes are carried as squares of three times the phasor
package svs_pkg;

  localparam int          SVS_DW        = 32;
  localparam int          SVS_AW        = 8;
  localparam int          SVS_VW        = 16;

  localparam logic [7:0]  SVS_OFS_CTRL   = 8'h00;
  localparam logic [7:0]  SVS_OFS_THRESH = 8'h04;
  localparam logic [7:0]  SVS_OFS_RATIO  = 8'h08;
  localparam logic [7:0]  SVS_OFS_DELAY  = 8'h0c;
  localparam logic [7:0]  SVS_OFS_STATUS = 8'h10;
  localparam logic [7:0]  SVS_OFS_ISTAT  = 8'h14;
  localparam logic [7:0]  SVS_OFS_IMASK  = 8'h18;

  localparam int          SVS_CTRL_EN    = 0;
  localparam int          SVS_CTRL_MODE  = 1;
  localparam int          SVS_ST_ALARM   = 0;
  localparam int          SVS_ST_TRIP    = 1;
  localparam int          SVS_ST_RATIO   = 2;
  localparam int          SVS_EV_ALARM   = 0;
  localparam int          SVS_EV_TRIP    = 1;

  localparam logic [31:0] SVS_RST_CTRL   = 32'h0;
  localparam logic [15:0] SVS_RST_THRESH = 16'hffff;
  localparam logic [7:0]  SVS_RST_RATIO  = 8'h64;
  localparam logic [31:0] SVS_RST_DELAY  = 32'h0;
  localparam logic [1:0]  SVS_RST_IMASK  = 2'h0;

  // sqrt(3)/2 in Q15
  localparam logic signed [15:0] SVS_K_Q15 = 16'sh6ed9;
  localparam logic [3:0]  SVS_THR_SCALE  = 4'h9;
  localparam logic [13:0] SVS_PCT_SCALE  = 14'h2710;

  typedef enum logic [1:0] {
    SVS_NEG_SEQ_OVERVOLTAGE_MODE,
    SVS_POS_SEQ_OVERVOLTAGE_MODE,
    SVS_POS_SEQ_UNDERVOLTAGE_MODE,
    SVS_MODE_OFF
  } svs_mode_e;

  typedef enum logic [1:0] {
    SVS_IDLE,
    SVS_TIMING,
    SVS_TRIPPED
  } svs_state_e;

endpackage

// *** verilog/svs_seq_calc.sv ***
// Purpose: symmetrical components from three phase phasors
// Assumes: phasors arrive as signed real/imag pairs on the block clock
// Notes:   two-stage pipeline; outputs |3*V1|^2 and |3*V2|^2
`timescale 1ns/100ps
`default_nettype none
module svs_seq_calc
  import svs_pkg::*;
#(
  parameter int W = SVS_VW
)(
  input  wire logic                   clk,
  input  wire logic                   arst_n,
  input  wire logic                   in_valid,
  input  wire logic signed [W-1:0]    va_re,
  input  wire logic signed [W-1:0]    va_im,
  input  wire logic signed [W-1:0]    vb_re,
  input  wire logic signed [W-1:0]    vb_im,
  input  wire logic signed [W-1:0]    vc_re,
  input  wire logic signed [W-1:0]    vc_im,
  output logic                        out_valid,
  output logic [2*(W+3)-1:0]          mag1_sq,
  output logic [2*(W+3)-1:0]          mag2_sq
);
  localparam int CW = W + 3;

  logic signed [CW-1:0] s1_re_r, s1_im_r, s2_re_r, s2_im_r;
  logic signed [CW-1:0] half_re, half_im, kd_im, kd_re;
  logic                 v1_r;

  function automatic logic signed [CW-1:0] mulk(input logic signed [W:0] d);
    logic signed [W+16:0] p;
    p = (W+17)'(d) * (W+17)'(SVS_K_Q15);
    return CW'(p >>> 15);
  endfunction

  function automatic logic [2*CW-1:0] sq(input logic signed [CW-1:0] re,
                                         input logic signed [CW-1:0] im);
    logic [2*CW-1:0] a;
    logic [2*CW-1:0] b;
    a = (2*CW)'(re * re);
    b = (2*CW)'(im * im);
    return a + b;
  endfunction

  always_comb
  begin
    half_re = CW'((W+1)'(vb_re) + (W+1)'(vc_re)) >>> 1;
    half_im = CW'((W+1)'(vb_im) + (W+1)'(vc_im)) >>> 1;
    kd_im   = mulk((W+1)'(vb_im) - (W+1)'(vc_im));
    kd_re   = mulk((W+1)'(vb_re) - (W+1)'(vc_re));
  end

  // every phase enters both sums, no single-phase shortcut
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      s1_re_r <= '0;
      s1_im_r <= '0;
      s2_re_r <= '0;
      s2_im_r <= '0;
    end
    else if (in_valid)
    begin
      s1_re_r <= CW'(va_re) - half_re - kd_im; // [RULE_02]
      s1_im_r <= CW'(va_im) - half_im + kd_re; // [RULE_02]
      s2_re_r <= CW'(va_re) - half_re + kd_im; // [RULE_02]
      s2_im_r <= CW'(va_im) - half_im - kd_re; // [RULE_02]
    end
  end

  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      v1_r      <= 1'b0;
      out_valid <= 1'b0;
      mag1_sq   <= '0;
      mag2_sq   <= '0;
    end
    else
    begin
      v1_r      <= in_valid;
      out_valid <= v1_r;
      if (v1_r)
      begin
        mag1_sq <= sq(s1_re_r, s1_im_r);
        mag2_sq <= sq(s2_re_r, s2_im_r);
      end
    end
  end

  a_zero_seq_only : assert property (@(posedge clk) disable iff (!arst_n) // [RULE_02]
    in_valid && va_re == vb_re && vb_re == vc_re && va_im == vb_im && vb_im == vc_im
    |=> ##1 out_valid && mag1_sq == '0 && mag2_sq == '0)
    else $error("equal phases gave nonzero sequence magnitude");

endmodule
`default_nettype wire

// *** verilog/svs_top.sv ***
// What this block does
// RULE_01 - three modes: negative overvoltage, positive overvoltage, positive undervoltage
// RULE_02 - sequence components come from all three phase voltages together
// RULE_03 - alarm rises at once when the supervised quantity crosses threshold
// RULE_04 - delay timer starts at crossing; trip only if crossing persists throughout
// RULE_05 - negative mode trips only with threshold and ratio both exceeded
// RULE_06 - ratio setting in percent, compared against 100 times V2 over V1
// RULE_07 - returning inside threshold clears alarm and restarts timer from zero
//
// Purpose: sequence voltage supervision with alarm, delayed trip and interrupt
// Assumes: phasor inputs come from logic on CLOCK; delay register counts clocks
// Notes:   reading the event register clears it; a new event in that cycle survives
`timescale 1ns/100ps
`default_nettype none
module svs_top
  import svs_pkg::*;
#(
  parameter int W = svs_pkg::SVS_VW
)(
  input  wire logic                        CLOCK,
  input  wire logic                        ARST_N,
  input  wire logic                        MEAS_VALID,
  input  wire logic signed [W-1:0]         VA_RE,
  input  wire logic signed [W-1:0]         VA_IM,
  input  wire logic signed [W-1:0]         VB_RE,
  input  wire logic signed [W-1:0]         VB_IM,
  input  wire logic signed [W-1:0]         VC_RE,
  input  wire logic signed [W-1:0]         VC_IM,
  input  wire logic [svs_pkg::SVS_AW-1:0]  ADDR,
  input  wire logic [svs_pkg::SVS_DW-1:0]  WDATA,
  input  wire logic                        WR,
  input  wire logic                        RD,
  output logic [svs_pkg::SVS_DW-1:0]       RDATA,
  output logic                             ALARM,
  output logic                             TRIP,
  output logic                             IRQ
);
  import svs_pkg::*;

  localparam int MW = 2*(W+3);
  localparam int XW = MW + 18;

  logic [31:0]      ctrl_r;
  logic [15:0]      thresh_r;
  logic [7:0]       ratio_pct_r;
  logic [31:0]      delay_r;
  logic [1:0]       ev_r, ev_nxt, imask_r;
  logic [31:0]      cnt_r, cnt_nxt;
  logic             cross_r, ratio_r;
  logic             m_valid;
  logic [MW-1:0]    m1_sq, m2_sq;
  logic [XW-1:0]    thr_x, m1_x, m2_x, m1_pct, m2_pct;
  logic             over1, under1, over2, ratio_hi, cross_c, trip_ok;
  logic             enabled;
  svs_mode_e        mode;
  svs_state_e       state_r, state_nxt;

  function automatic logic [XW-1:0] scale(input logic [XW-1:0] v,
                                          input logic [15:0]  k);
    return XW'(v * XW'(k));
  endfunction

  svs_seq_calc #(
    .W        (W)
  ) u_calc (
    .clk      (CLOCK),
    .arst_n   (ARST_N),
    .in_valid (MEAS_VALID),
    .va_re    (VA_RE),
    .va_im    (VA_IM),
    .vb_re    (VB_RE),
    .vb_im    (VB_IM),
    .vc_re    (VC_RE),
    .vc_im    (VC_IM),
    .out_valid(m_valid),
    .mag1_sq  (m1_sq),
    .mag2_sq  (m2_sq)
  );

  assign enabled = ctrl_r[SVS_CTRL_EN];
  assign mode    = svs_mode_e'(ctrl_r[SVS_CTRL_MODE +: 2]);

  // magnitudes are of 3V, so the threshold is scaled by 9 in the square domain
  always_comb
  begin
    m1_x     = XW'(m1_sq);
    m2_x     = XW'(m2_sq);
    thr_x    = scale(scale(XW'(thresh_r), thresh_r), 16'(SVS_THR_SCALE));
    over1    = m1_x > thr_x;
    under1   = m1_x < thr_x;
    over2    = m2_x > thr_x;
    // squared form avoids a divider: 100*V2/V1 > UNBALANCE_RATIO_SETTING
    m2_pct   = scale(m2_x, 16'(SVS_PCT_SCALE));                        // [RULE_06]
    m1_pct   = scale(scale(m1_x, 16'(ratio_pct_r)), 16'(ratio_pct_r)); // [RULE_06]
    ratio_hi = m2_pct > m1_pct;                                        // [RULE_06]
    case (mode)                                                        // [RULE_01]
      SVS_NEG_SEQ_OVERVOLTAGE_MODE:  cross_c = over2;
      SVS_POS_SEQ_OVERVOLTAGE_MODE:  cross_c = over1;
      SVS_POS_SEQ_UNDERVOLTAGE_MODE: cross_c = under1;
      default:                       cross_c = 1'b0;
    endcase
  end

  always_ff @(posedge CLOCK or negedge ARST_N)
  begin
    if (!ARST_N)
    begin
      cross_r <= 1'b0;
      ratio_r <= 1'b0;
    end
    else if (!enabled)
    begin
      cross_r <= 1'b0;
      ratio_r <= 1'b0;
    end
    else if (m_valid)
    begin
      cross_r <= cross_c;
      ratio_r <= ratio_hi;
    end
  end

  // ratio only gates the trip in negative-sequence mode
  assign trip_ok = (mode != SVS_NEG_SEQ_OVERVOLTAGE_MODE) || ratio_r; // [RULE_05]

  always_comb
  begin
    state_nxt = state_r;
    cnt_nxt   = cnt_r;
    case (state_r)
      SVS_IDLE:
      begin
        cnt_nxt = '0;
        if (cross_r)
          state_nxt = SVS_TIMING; // [RULE_03]
      end
      SVS_TIMING:
      begin
        if (!cross_r)
        begin
          state_nxt = SVS_IDLE; // [RULE_07]
          cnt_nxt   = '0;       // [RULE_07]
        end
        else if (cnt_r >= delay_r && trip_ok)
          state_nxt = SVS_TRIPPED; // [RULE_04] [RULE_05]
        else if (cnt_r < delay_r)
          cnt_nxt = cnt_r + 32'h1; // [RULE_04]
      end
      SVS_TRIPPED:
      begin
        if (!cross_r)
        begin
          state_nxt = SVS_IDLE;
          cnt_nxt   = '0;
        end
        else if (!trip_ok)
          state_nxt = SVS_TIMING;
      end
      default:
      begin
        state_nxt = SVS_IDLE;
        cnt_nxt   = '0;
      end
    endcase
  end

  always_ff @(posedge CLOCK or negedge ARST_N)
  begin
    if (!ARST_N)
    begin
      state_r <= SVS_IDLE;
      cnt_r   <= '0;
      ALARM   <= 1'b0;
      TRIP    <= 1'b0;
    end
    else
    begin
      state_r <= state_nxt;
      cnt_r   <= cnt_nxt;
      ALARM   <= state_nxt != SVS_IDLE;    // [RULE_03]
      TRIP    <= state_nxt == SVS_TRIPPED; // [RULE_04]
    end
  end

  // register writes
  always_ff @(posedge CLOCK or negedge ARST_N)
  begin
    if (!ARST_N)
    begin
      ctrl_r      <= SVS_RST_CTRL;
      thresh_r    <= SVS_RST_THRESH;
      ratio_pct_r <= SVS_RST_RATIO;
      delay_r     <= SVS_RST_DELAY;
      imask_r     <= SVS_RST_IMASK;
    end
    else if (WR)
    begin
      case (ADDR)
        SVS_OFS_CTRL:   ctrl_r      <= {29'h0, WDATA[2:0]};
        SVS_OFS_THRESH: thresh_r    <= WDATA[15:0];
        SVS_OFS_RATIO:  ratio_pct_r <= WDATA[7:0];
        SVS_OFS_DELAY:  delay_r     <= WDATA;
        SVS_OFS_IMASK:  imask_r     <= WDATA[1:0];
        default:        ;
      endcase
    end
  end

  // set beats the read-clear in the same cycle
  always_comb
  begin
    ev_nxt = ev_r;
    if (RD && ADDR == SVS_OFS_ISTAT)
      ev_nxt = '0;
    if (state_nxt != SVS_IDLE && !ALARM)
      ev_nxt[SVS_EV_ALARM] = 1'b1;
    if (state_nxt == SVS_TRIPPED && !TRIP)
      ev_nxt[SVS_EV_TRIP] = 1'b1;
  end

  always_ff @(posedge CLOCK or negedge ARST_N)
  begin
    if (!ARST_N)
    begin
      ev_r <= '0;
      IRQ  <= 1'b0;
    end
    else
    begin
      ev_r <= ev_nxt;
      IRQ  <= |(ev_nxt & imask_r);
    end
  end

  always_ff @(posedge CLOCK or negedge ARST_N)
  begin
    if (!ARST_N)
      RDATA <= '0;
    else if (RD)
    begin
      case (ADDR)
        SVS_OFS_CTRL:   RDATA <= ctrl_r;
        SVS_OFS_THRESH: RDATA <= {16'h0, thresh_r};
        SVS_OFS_RATIO:  RDATA <= {24'h0, ratio_pct_r};
        SVS_OFS_DELAY:  RDATA <= delay_r;
        SVS_OFS_STATUS: RDATA <= {29'h0, ratio_r, TRIP, ALARM};
        SVS_OFS_ISTAT:  RDATA <= {30'h0, ev_r};
        SVS_OFS_IMASK:  RDATA <= {30'h0, imask_r};
        default:        RDATA <= '0;
      endcase
    end
    else
      RDATA <= '0;
  end

  a_undervolt_mode : assert property (@(posedge CLOCK) disable iff (!ARST_N) // [RULE_01]
    m_valid && enabled && mode == SVS_POS_SEQ_UNDERVOLTAGE_MODE
    |=> cross_r == ($past(m1_sq) < $past(thr_x[MW-1:0])))
    else $error("undervoltage mode compare wrong");

  a_alarm_at_once : assert property (@(posedge CLOCK) disable iff (!ARST_N) // [RULE_03]
    state_r == SVS_IDLE && cross_r |=> ALARM && cnt_r == 32'h0)
    else $error("alarm not raised at crossing");

  a_trip_after_dly : assert property (@(posedge CLOCK) disable iff (!ARST_N) // [RULE_04]
    $rose(TRIP) |-> $past(cnt_r) >= $past(delay_r) && $past(cross_r))
    else $error("trip before delay expired");

  a_trip_needs_cross : assert property (@(posedge CLOCK) disable iff (!ARST_N) // [RULE_04]
    TRIP && !cross_r |=> !TRIP && !ALARM)
    else $error("trip held after quantity returned");

  a_neg_ratio_gate : assert property (@(posedge CLOCK) disable iff (!ARST_N) // [RULE_05]
    $rose(TRIP) && $past(mode) == SVS_NEG_SEQ_OVERVOLTAGE_MODE |-> $past(ratio_r))
    else $error("negative mode tripped without ratio");

  a_zero_pct_ratio : assert property (@(posedge CLOCK) disable iff (!ARST_N) // [RULE_06]
    m_valid && enabled && ratio_pct_r == 8'h0 && m2_sq != '0 |=> ratio_r)
    else $error("ratio not exceeded at zero percent setting");

  a_timer_restart : assert property (@(posedge CLOCK) disable iff (!ARST_N) // [RULE_07]
    state_r == SVS_TIMING && !cross_r |=> !ALARM && cnt_r == 32'h0 ##1 !TRIP)
    else $error("timer not cleared on return");

  a_alarm_no_wait : assert property (@(posedge CLOCK) disable iff (!ARST_N) // [RULE_03]
    $rose(cross_r) |=> ALARM)
    else $error("alarm late after crossing");

  a_timer_counts : assert property (@(posedge CLOCK) disable iff (!ARST_N) // [RULE_04]
    state_r == SVS_TIMING && cross_r && cnt_r < delay_r |=> cnt_r == $past(cnt_r) + 32'h1)
    else $error("delay timer did not advance");

  a_disable_clears : assert property (@(posedge CLOCK) disable iff (!ARST_N) // [RULE_01]
    !enabled |=> !cross_r && !ratio_r)
    else $error("disabled block kept a crossing");

  a_drop_clears : assert property (@(posedge CLOCK) disable iff (!ARST_N) // [RULE_07]
    ALARM && !cross_r |=> !ALARM && cnt_r == 32'h0)
    else $error("alarm or timer kept after return");

endmodule
`default_nettype wire
